// ---- core/adc_ctrl_defs.svh ----
// register offsets, field positions and reset values of the converter control block
// assumes a 32-bit classic wishbone slave, byte addresses, one register per aligned word
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// register byte offsets
`define OFS_SC1          8'h00
`define OFS_SC2          8'h04
`define OFS_RES_HIGH     8'h08
`define OFS_RES_LOW      8'h0C
`define OFS_CMP_HIGH     8'h10
`define OFS_CMP_LOW      8'h14
`define OFS_CFG          8'h18
`define OFS_PIN_ONE      8'h1C
`define OFS_PIN_TWO      8'h20
`define OFS_PWR          8'h24

// first control register fields
`define SC1_DONE_BIT     7
`define SC1_IEN_BIT      6
`define SC1_CONT_BIT     5
`define SC1_CH_MSB       4
`define SC1_CH_LSB       0

// second control register fields
`define SC2_ACTIVE_BIT   7
`define SC2_TRIG_BIT     6
`define SC2_CMPEN_BIT    5
`define SC2_CMPDIR_BIT   4

// configuration, power control fields
`define CFG_MODE8_BIT    0
`define PWR_LOWVOLT_DETECT_ENABLE_BIT     1
`define PWR_LOWVOLT_STOP_DETECT_ENABLE_BIT    0

// channel codes
`define CH_DISABLED      5'h1F
`define CH_LAST_PIN      5'h0B

// reset values
`define SC1_RESET        8'h1F
`define SC2_RESET        8'h00
`define CFG_RESET        8'h00
`define PIN_RESET        8'h00
`define PWR_RESET        8'h00
`define CMP_RESET        10'h000

`endif

// ---- core/adc_ctrl_pkg.sv ----
// types shared by the converter control block
// assumes nothing beyond a systemverilog compiler
package adc_ctrl_pkg;

	typedef enum logic [0:0] {
		SEQ_IDLE,
		SEQ_CONV
	} seq_state_e;

	typedef logic [4:0] channel_t;
	typedef logic [9:0] sample_t;

endpackage

// ---- core/adc_result_shaper.sv ----
// result formatting and automatic compare for one finished conversion
// assumes raw data from the converter is 10 bits, msb first significance
`timescale 1ns/1ps
`default_nettype none

module adc_result_shaper
	import adc_ctrl_pkg::*;
(
	input  wire adc_ctrl_pkg::sample_t raw_data,   // converter output word
	input  wire logic                  mode8,      // 1 = 8-bit resolution
	input  wire adc_ctrl_pkg::sample_t cmp_level,  // programmed compare level
	input  wire logic                  cmp_dir,    // 0 below, 1 at or above
	output var   adc_ctrl_pkg::sample_t result,    // right-justified result
	output logic                       cmp_true    // compare condition met
);

	sample_t level_eff;

	always_comb begin
		if (mode8) begin
			result    = {2'h0, raw_data[9:2]};
			level_eff = {2'h0, cmp_level[7:0]};           // high compare bits unused in 8-bit
		end else begin
			result    = raw_data;
			level_eff = cmp_level;
		end
	end

	always_comb begin
		if (cmp_dir) begin
			cmp_true = (result >= level_eff);
		end else begin
			cmp_true = (result < level_eff);
		end
	end

endmodule // adc_result_shaper

`default_nettype wire

// ---- core/adc_conv_ctrl.sv ----
// digital control of a 10-bit successive approximation converter: registers, channel mux, sequencer
// assumes analog mux and converter outside; conv_done and hw trigger arrive asynchronously
//
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

`include "adc_ctrl_defs.svh"

module adc_conv_ctrl
	import adc_ctrl_pkg::*;
#(
	parameter int PIN_CHANNELS = 12                      // pin-connected inputs
) (
	input  wire logic                    clk_sys,           // bus clock, 100 MHz
	input  wire logic                    rstn,              // async reset, active low
	// classic wishbone slave
	input  wire logic                    wb_cyc_i,          // cycle
	input  wire logic                    wb_stb_i,          // strobe
	input  wire logic                    wb_we_i,           // write enable
	input  wire logic [7:0]              wb_adr_i,          // byte address
	input  wire logic [3:0]              wb_sel_i,          // byte lanes
	input  wire logic [31:0]             wb_dat_i,          // write data
	output logic      [31:0]             wb_dat_o,          // read data
	output logic                         wb_ack_o,          // acknowledge
	// converter and mux side
	input  wire logic                    hw_trigger_in,     // periodic wake counter overflow
	input  wire logic                    stop_mode_in,      // system is in stop mode
	input  wire logic                    conv_done_in,      // converter finished, level
	input  wire adc_ctrl_pkg::sample_t   conv_data_in,      // converter data, stable with done
	output logic                         conv_start,        // one-cycle start pulse
	output logic                         conv_abort,        // one-cycle abort pulse
	output logic                         conv_power_en,     // converter powered
	output var   adc_ctrl_pkg::channel_t mux_select,        // selected input code
	output logic                         mux_isolate,       // all sources disconnected
	output logic [PIN_CHANNELS-1:0]      pin_analog_enable, // per-pin analog enables
	output logic                         conv_irq           // conversion interrupt request
);

	// register state
	logic                    done_flag_q;
	logic                    irq_en_q;
	logic                    cont_q;
	channel_t                channel_q;
	logic                    trig_sel_q;
	logic                    cmp_en_q;
	logic                    cmp_dir_q;
	logic                    mode8_q;
	sample_t                 cmp_level_q;
	sample_t                 result_q;
	logic [15:0]             pin_en_q;
	logic                    lowvolt_detect_enable_q;
	logic                    lowvolt_stop_detect_enable_q;
	seq_state_e              state_q;
	seq_state_e              state_d;
	logic                    start_d;
	logic                    abort_d;
	logic [2:0]              sync1_q;
	logic [2:0]              sync2_q;
	logic                    hw_prev_q;
	logic                    done_prev_q;
	logic                    ack_q;
	logic [31:0]             rdata_q;

	// bus decode
	logic                    take;
	logic                    wr;
	logic                    rd;
	logic                    sc1_wr;
	logic                    res_low_rd;
	logic [7:0]              wbyte;
	logic [7:0]              rbyte;

	// synchronised inputs, second stage only
	logic                    hw_s;
	logic                    stop_s;
	logic                    done_s;

	// sequencer terms
	logic                    run_ok;
	logic                    done_ev;
	logic                    hw_ev;
	logic                    new_off;
	logic                    cur_off;
	sample_t                 shaped;
	logic                    cmp_hit;
	logic                    result_load;

	assign take       = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr         = take & wb_we_i & wb_sel_i[0];
	assign rd         = take & ~wb_we_i;
	assign wbyte      = wb_dat_i[7:0];
	assign sc1_wr     = wr & (wb_adr_i == `OFS_SC1);
	assign res_low_rd = rd & (wb_adr_i == `OFS_RES_LOW);

	// two-stage synchronisers for pins from outside the clock domain
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
		end else begin
			sync1_q <= {conv_done_in, stop_mode_in, hw_trigger_in};
			sync2_q <= sync1_q;
		end
	end

	assign hw_s   = sync2_q[0];
	assign stop_s = sync2_q[1];
	assign done_s = sync2_q[2];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			hw_prev_q   <= 1'b0;
			done_prev_q <= 1'b0;
		end else begin
			hw_prev_q   <= hw_s;
			done_prev_q <= done_s;
		end
	end

	assign hw_ev   = hw_s & ~hw_prev_q;
	assign done_ev = (state_q == SEQ_CONV) & done_s & ~done_prev_q;
	assign run_ok  = ~stop_s | (lowvolt_detect_enable_q & lowvolt_stop_detect_enable_q);
	assign new_off = (wbyte[`SC1_CH_MSB:`SC1_CH_LSB] == `CH_DISABLED);
	assign cur_off = (channel_q == `CH_DISABLED);

	// conversion sequencer: write has priority over completion and trigger
	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		abort_d = 1'b0;
		if (sc1_wr) begin
			abort_d = (state_q == SEQ_CONV);
			if (!new_off && !trig_sel_q && run_ok) begin
				state_d = SEQ_CONV;
				start_d = 1'b1;
			end else begin
				state_d = SEQ_IDLE;
			end
		end else if ((state_q == SEQ_CONV) && !run_ok) begin
			state_d = SEQ_IDLE;
			abort_d = 1'b1;
		end else if (done_ev) begin
			if (cont_q && !cur_off) begin
				state_d = SEQ_CONV;
				start_d = 1'b1;
			end else begin
				state_d = SEQ_IDLE;
			end
		end else if ((state_q == SEQ_IDLE) && trig_sel_q && hw_ev && !cur_off && run_ok) begin
			state_d = SEQ_CONV;
			start_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q       <= SEQ_IDLE;
			conv_start    <= 1'b0;
			conv_abort    <= 1'b0;
			conv_power_en <= 1'b0;
		end else begin
			state_q       <= state_d;
			conv_start    <= start_d;
			conv_abort    <= abort_d;
			conv_power_en <= (state_d == SEQ_CONV);
		end
	end

	// reserved codes are not filtered: converter runs, result is whatever it gives
	adc_result_shaper u_shaper (
		.raw_data  (conv_data_in),
		.mode8     (mode8_q),
		.cmp_level (cmp_level_q),
		.cmp_dir   (cmp_dir_q),
		.result    (shaped),
		.cmp_true  (cmp_hit)
	);

	assign result_load = done_ev & (~cmp_en_q | cmp_hit);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			result_q <= 10'h000;
		end else if (result_load) begin
			result_q <= shaped;
		end
	end

	// completion flag: a finish in the clearing cycle still sets it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			done_flag_q <= 1'b0;
		end else if (result_load) begin
			done_flag_q <= 1'b1;
		end else if (sc1_wr || res_low_rd) begin
			done_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			conv_irq <= 1'b0;
		end else begin
			conv_irq <= done_flag_q & irq_en_q;
		end
	end

	// first control register; the written flag bit is dropped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_en_q  <= 1'((`SC1_RESET >> `SC1_IEN_BIT) & 8'h01);
			cont_q    <= 1'((`SC1_RESET >> `SC1_CONT_BIT) & 8'h01);
			channel_q <= `CH_DISABLED;
		end else if (sc1_wr) begin
			irq_en_q  <= wbyte[`SC1_IEN_BIT];
			cont_q    <= wbyte[`SC1_CONT_BIT];
			channel_q <= wbyte[`SC1_CH_MSB:`SC1_CH_LSB];
		end
	end

	// second control, configuration, compare level and power control
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			trig_sel_q  <= 1'b0;
			cmp_en_q    <= 1'b0;
			cmp_dir_q   <= 1'b0;
			mode8_q     <= 1'b0;
			cmp_level_q <= `CMP_RESET;
			lowvolt_detect_enable_q      <= 1'b0;
			lowvolt_stop_detect_enable_q     <= 1'b0;
		end else if (wr) begin
			case (wb_adr_i)
				`OFS_SC2: begin
					trig_sel_q <= wbyte[`SC2_TRIG_BIT];
					cmp_en_q   <= wbyte[`SC2_CMPEN_BIT];
					cmp_dir_q  <= wbyte[`SC2_CMPDIR_BIT];
				end
				`OFS_CMP_HIGH: begin
					cmp_level_q[9:8] <= wbyte[1:0];
				end
				`OFS_CMP_LOW: begin
					cmp_level_q[7:0] <= wbyte;
				end
				`OFS_CFG: begin
					mode8_q <= wbyte[`CFG_MODE8_BIT];
				end
				`OFS_PWR: begin
					lowvolt_detect_enable_q  <= wbyte[`PWR_LOWVOLT_DETECT_ENABLE_BIT];
					lowvolt_stop_detect_enable_q <= wbyte[`PWR_LOWVOLT_STOP_DETECT_ENABLE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// pin analog enables, one bit per pin-connected channel
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_en_q <= 16'h0000;
		end else if (wr && (wb_adr_i == `OFS_PIN_ONE)) begin
			pin_en_q[7:0] <= wbyte;
		end else if (wr && (wb_adr_i == `OFS_PIN_TWO)) begin
			pin_en_q[15:8] <= wbyte;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIN_CHANNELS; gi++) begin : g_pin
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					pin_analog_enable[gi] <= 1'b0;
				end else begin
					pin_analog_enable[gi] <= pin_en_q[gi];
				end
			end
		end
	endgenerate

	// channel routing: all five bits go out, up to 28 inputs plus references
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mux_select  <= `CH_DISABLED;
			mux_isolate <= 1'b1;
		end else begin
			mux_select  <= channel_q;
			mux_isolate <= cur_off;
		end
	end

	// read mux
	always_comb begin
		case (wb_adr_i)
			`OFS_SC1:      rbyte = {done_flag_q, irq_en_q, cont_q, channel_q};
			`OFS_SC2:      rbyte = {state_q == SEQ_CONV, trig_sel_q, cmp_en_q, cmp_dir_q, 4'h0};
			`OFS_RES_HIGH: rbyte = {6'h00, result_q[9:8]};
			`OFS_RES_LOW:  rbyte = result_q[7:0];
			`OFS_CMP_HIGH: rbyte = {6'h00, cmp_level_q[9:8]};
			`OFS_CMP_LOW:  rbyte = cmp_level_q[7:0];
			`OFS_CFG:      rbyte = {7'h00, mode8_q};
			`OFS_PIN_ONE:  rbyte = pin_en_q[7:0];
			`OFS_PIN_TWO:  rbyte = pin_en_q[15:8];
			`OFS_PWR:      rbyte = {6'h00, lowvolt_detect_enable_q, lowvolt_stop_detect_enable_q};
			default:       rbyte = 8'h00;
		endcase
	end

	// one wait state: ack is registered, unmapped addresses answer with zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q <= take;
			if (rd) begin
				rdata_q <= {24'h000000, rbyte};
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

endmodule // adc_conv_ctrl

`default_nettype wire

// ---- tb/adc_conv_ctrl_sva.sv ----
// port assertions for the converter control block
// assumes bind into adc_conv_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module adc_conv_ctrl_sva
	import adc_ctrl_pkg::*;
#(
	parameter int PIN_CHANNELS = 12 // pin-connected inputs
) (
	input wire logic                    clk_sys,           // clock
	input wire logic                    rstn,              // reset
	input wire logic                    wb_cyc_i,          // cycle
	input wire logic                    wb_stb_i,          // strobe
	input wire logic [31:0]             wb_dat_o,          // read data
	input wire logic                    wb_ack_o,          // ack
	input wire logic                    conv_start,        // start pulse
	input wire logic                    conv_abort,        // abort pulse
	input wire logic                    conv_power_en,     // power
	input wire adc_ctrl_pkg::channel_t  mux_select,        // channel
	input wire logic                    mux_isolate,       // isolate
	input wire logic [PIN_CHANNELS-1:0] pin_analog_enable, // pin enables
	input wire logic                    conv_irq           // irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	property p_ack_wait;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_dat_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
	endproperty
	property p_isolate;
		mux_isolate == (mux_select == `CH_DISABLED);
	endproperty
	property p_start_chan;
		conv_start |=> !mux_isolate;
	endproperty
	property p_start_power;
		conv_start |-> conv_power_en ##1 !conv_start;
	endproperty
	property p_abort_off;
		conv_abort && !conv_start |-> !conv_power_en;
	endproperty
	property p_cfg_follow;
		$changed(mux_select) || $changed(pin_analog_enable) |-> $past(wb_ack_o);
	endproperty
	a_ack_wait: assert property (p_ack_wait) else $error("ack not one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
	a_isolate: assert property (p_isolate) else $error("isolate differs from disabled code");
	a_start_chan: assert property (p_start_chan) else $error("start with disabled channel");
	a_start_power: assert property (p_start_power) else $error("start without power or too long");
	a_abort_off: assert property (p_abort_off) else $error("power kept after abort");
	a_cfg_follow: assert property (p_cfg_follow) else $error("select changed without write");
	c_abort: cover property (conv_abort && conv_start);
	c_stop: cover property (conv_abort && !conv_start);
	c_irq: cover property ($rose(conv_irq));
endmodule // adc_conv_ctrl_sva
bind adc_conv_ctrl adc_conv_ctrl_sva #(.PIN_CHANNELS(PIN_CHANNELS)) u_adc_conv_ctrl_sva (.clk_sys(clk_sys),
	.rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.conv_start(conv_start), .conv_abort(conv_abort), .conv_power_en(conv_power_en),
	.mux_select(mux_select), .mux_isolate(mux_isolate), .pin_analog_enable(pin_analog_enable),
	.conv_irq(conv_irq));
`default_nettype wire

// ---- tb/adc_conv_model.sv ----
// behavioural converter on the far side of the control block
// assumes start and abort are one-cycle pulses from the controller
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model
	import adc_ctrl_pkg::*;
(
	input  wire logic                  clk_sys,      // clock
	input  wire logic                  rstn,         // reset
	input  wire logic                  conv_start,   // start pulse
	input  wire logic                  conv_abort,   // abort pulse
	input  wire logic                  conv_power_en, // power
	input  wire logic                  slow,         // long conversion
	input  wire adc_ctrl_pkg::sample_t next_data,    // value to deliver
	output logic                       conv_done_in, // done level
	output var   adc_ctrl_pkg::sample_t conv_data_in // result
);
	logic [5:0] cnt_q;
	logic       busy_q;
	// data toggles while not valid, so stale values never look right
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			cnt_q <= 6'h00;
			conv_done_in <= 1'b0;
			conv_data_in <= 10'h000;
		end else if ((conv_abort || (busy_q && !conv_power_en)) && !conv_start) begin
			busy_q <= 1'b0;
			conv_done_in <= 1'b0;
		end else if (conv_start) begin
			busy_q <= 1'b1;
			conv_done_in <= 1'b0;
			cnt_q <= slow ? 6'h28 : 6'h06;
			conv_data_in <= ~conv_data_in;
		end else if (busy_q && cnt_q == 6'h00) begin
			busy_q <= 1'b0;
			conv_done_in <= 1'b1;
			conv_data_in <= next_data;
		end else if (busy_q) begin
			cnt_q <= cnt_q - 6'h01;
			conv_data_in <= ~conv_data_in;
		end
	end
endmodule // adc_conv_model
`default_nettype wire

// ---- tb/sar_adc_channel_conversion_control_tb_top.sv ----
// self-checking bench for the converter control block
// assumes the behavioural converter model on the far side
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defs.svh"
module sar_adc_channel_conversion_control_tb_top;
	import adc_ctrl_pkg::*;
	logic        clk_sys, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, hw_trigger_in, stop_mode_in, slow;
	logic        conv_done_in, conv_start, conv_abort, conv_power_en, mux_isolate, conv_irq, ien, dir;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [11:0] pin_analog_enable;
	sample_t     conv_data_in, next_data, lvl;
	channel_t    mux_select, ch;
	channel_t    ch_list [6] = '{5'h00, 5'h0B, 5'h1B, 5'h1C, 5'h1D, 5'h05};
	int          fail_count, cmp_count, starts, s0, seed, i, aborts, a0;

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (conv_start) starts <= starts + 1;
	always @(posedge clk_sys) if (conv_abort) aborts <= aborts + 1;

	adc_conv_ctrl #(.PIN_CHANNELS(12)) u_adc_conv_ctrl (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hw_trigger_in(hw_trigger_in), .stop_mode_in(stop_mode_in),
		.conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .conv_start(conv_start),
		.conv_abort(conv_abort), .conv_power_en(conv_power_en), .mux_select(mux_select),
		.mux_isolate(mux_isolate), .pin_analog_enable(pin_analog_enable), .conv_irq(conv_irq));
	adc_conv_model u_adc_conv_model (.clk_sys(clk_sys), .rstn(rstn), .conv_start(conv_start),
		.conv_abort(conv_abort), .conv_power_en(conv_power_en), .slow(slow), .next_data(next_data),
		.conv_done_in(conv_done_in), .conv_data_in(conv_data_in));

	function automatic logic [31:0] exp_res(input sample_t d, input logic m8);
		return m8 ? {24'h0, d[9:2]} : {22'h0, d};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	// done passes two sync flops plus one processing cycle, irq one more
	task automatic wait_done();
		// an old done level drops only at the edge that ends the start call
		@(posedge clk_sys);
		for (int k = 0; k < 200 && conv_done_in !== 1'b1; k++) @(posedge clk_sys);
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic summarize();
		$display("compares=%0d mismatches=%0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#600000;
		fail_count++;
		summarize();
	end

	initial begin
		seed = 32'hbf26;
		{wb_cyc_i, wb_stb_i, wb_we_i, hw_trigger_in, stop_mode_in, slow, rstn} = '0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h1;
		wb_dat_i = 32'h0;
		next_data = 10'h000;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		chk(mux_isolate, 1'b1);
		chk(conv_power_en, 1'b0);
		wb(0, `OFS_SC1, 8'h00);
		chk(rd, 32'h1F);
		wb(0, 8'h3C, 8'h00);
		chk(rd, 32'h0);
		for (i = 0; i < 12; i++) begin
			ch = (i < 6) ? ch_list[i] : 5'($unsigned($random(seed)) % 31);
			ien = 1'($random(seed));
			next_data <= 10'($random(seed));
			slow <= i[0];
			wb(1, `OFS_CFG, {7'h0, i >= 8});
			s0 = starts;
			wb(1, `OFS_SC1, {1'b1, ien, 1'b0, ch});
			wait_done();
			chk(starts - s0, 1);
			chk(mux_select, ch);
			chk(conv_power_en, 1'b0);
			chk(conv_irq, ien);
			wb(0, `OFS_SC1, 8'h00);
			chk(rd, {24'h0, 1'b1, ien, 1'b0, ch});
			wb(0, `OFS_RES_HIGH, 8'h00);
			chk(rd, exp_res(next_data, i >= 8) >> 8);
			wb(0, `OFS_RES_LOW, 8'h00);
			chk(rd, exp_res(next_data, i >= 8) & 32'hFF);
			wb(0, `OFS_SC1, 8'h00);
			chk(rd[7], 1'b0);
		end
		wb(1, `OFS_CFG, 8'h00);
		s0 = starts;
		wb(1, `OFS_SC1, 8'h23);
		for (i = 0; i < 400 && starts < s0 + 3; i++) @(posedge clk_sys);
		chk(starts >= s0 + 3, 1'b1);
		wb(0, `OFS_SC2, 8'h00);
		chk(rd, 32'h80);
		a0 = aborts;
		wb(1, `OFS_SC1, 8'h23);
		repeat (2) @(posedge clk_sys);
		chk(aborts - a0, 1);
		wb(1, `OFS_SC1, 8'h3F);
		repeat (2) @(posedge clk_sys);
		s0 = starts;
		repeat (60) @(posedge clk_sys);
		chk(starts, s0);
		chk({conv_power_en, mux_isolate}, 2'b01);
		wb(0, `OFS_SC2, 8'h00);
		chk(rd, 32'h00);
		for (i = 0; i < 6; i++) begin
			lvl = 10'($random(seed));
			dir = 1'($random(seed));
			next_data <= 10'($random(seed));
			wb(1, `OFS_CMP_HIGH, {6'h0, lvl[9:8]});
			wb(1, `OFS_CMP_LOW, lvl[7:0]);
			wb(1, `OFS_SC2, {2'b00, 1'b1, dir, 4'h0});
			wb(1, `OFS_SC1, 8'h04);
			wait_done();
			wb(0, `OFS_SC1, 8'h00);
			chk(rd[7], dir ? next_data >= lvl : next_data < lvl);
		end
		wb(1, `OFS_SC2, 8'h40);
		s0 = starts;
		wb(1, `OFS_SC1, 8'h02);
		repeat (20) @(posedge clk_sys);
		chk(starts, s0);
		for (i = 0; i < 3; i++) begin
			stop_mode_in <= (i > 0);
			wb(1, `OFS_PWR, {6'h0, 1'b1, i == 2});
			s0 = starts;
			next_data <= 10'($random(seed));
			hw_trigger_in <= 1'b1;
			repeat (4) @(posedge clk_sys);
			hw_trigger_in <= 1'b0;
			wait_done();
			chk(starts - s0, i != 1);
		end
		for (i = 0; i < 4; i++) begin
			s0 = $random(seed);
			wb(1, `OFS_PIN_ONE, s0[7:0]);
			wb(1, `OFS_PIN_TWO, s0[15:8]);
			@(posedge clk_sys);
			chk(pin_analog_enable, {s0[11:8], s0[7:0]});
		end
		summarize();
	end
endmodule // sar_adc_channel_conversion_control_tb_top
`default_nettype wire
